// [logic/asirq_pkg.sv]
// Shared constants of the sequencer interrupt and trigger register block.
package asirq_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_RAW_IRQ  = 12'h004;
  localparam logic [11:0] OFF_MASK     = 12'h008;
  localparam logic [11:0] OFF_ISC      = 12'h00c;
  localparam logic [11:0] OFF_OVF      = 12'h010;
  localparam logic [11:0] OFF_TRIG_SEL = 12'h014;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_MASK     = 32'h0000_0000;
  localparam logic [31:0] RST_RAW_IRQ  = 32'h0000_0000;
  localparam logic [31:0] RST_OVF      = 32'h0000_0000;
  localparam logic [31:0] RST_TRIG_SEL = 32'h0000_0000;
  localparam logic [31:0] READ_IDLE    = 32'h0000_0000;

  // ==========================================================================
  // Trigger select field layout and codes
  localparam int unsigned TRIG_W   = 4;
  localparam int unsigned MAX_SEQ  = 4;
  localparam logic [3:0] TRIG_SW    = 4'h0;
  localparam logic [3:0] TRIG_CMP   = 4'h1;
  localparam logic [3:0] TRIG_PIN   = 4'h4;
  localparam logic [3:0] TRIG_TIMER = 4'h5;
  localparam logic [3:0] TRIG_PWM   = 4'h6;
  localparam logic [3:0] TRIG_ALWAYS = 4'hf;

endpackage : asirq_pkg

// [logic/asirq_regs.sv]
// Interrupt mask, status, overflow and trigger select registers of a four-sequencer converter.
// ============================================================================
// Notes on behaviour
// [R1] A sequencer's raw interrupt reaches the processor only while its mask bit is one.
// [R2] Reading masked status returns raw flag AND mask bit, per sequencer.
// [R3] Writing one to masked status clears status and raw flag; zero leaves them.
// [R4] That write clears the raw flag even when the mask bit is zero.
// [R5] The delivered interrupt is a level held while raw and mask are one.
// [R6] Full FIFO plus write request drops the newest result and sets overflow.
// [R7] Overflow bits stay set until a one is written to them.
// [R8] Trigger select holds a four-bit field per sequencer, sequencer n at 4n+3:4n.
// [R9] Codes: 0 software, 1 comparator, 4 pin, 5 timer, 6 PWM, 15 continuous.
// [R10] Each sequencer takes its own trigger, independent of the others.
// [R11] Software preserves reserved bits and ignores their read value.
// [R12] Raw flag is set when a sample with interrupt enable completes conversion.
// [R13] Reserved trigger codes never trigger the selecting sequencer.
`timescale 1ns/1ps
module asirq_regs #(
  parameter int NUM_SEQ = 4
) (
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic [11:0]        addr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [31:0]        rdata_o,
  input  wire logic [NUM_SEQ-1:0] sample_done_i,
  input  wire logic [NUM_SEQ-1:0] sample_irq_enable_i,
  input  wire logic [NUM_SEQ-1:0] fifo_wr_req_i,
  input  wire logic [NUM_SEQ-1:0] fifo_full_i,
  output logic      [NUM_SEQ-1:0] fifo_wr_en_o,
  input  wire logic [NUM_SEQ-1:0] sw_initiate_i,
  input  wire logic               trig_cmp_i,
  input  wire logic               trig_pin_i,
  input  wire logic               trig_timer_i,
  input  wire logic               trig_pwm_i,
  output logic      [NUM_SEQ-1:0] seq_trigger_o,
  output logic      [NUM_SEQ-1:0] seq_irq_o,
  output logic                    irq_o
);

  // ==========================================================================
  // Elaboration check
  // The register layout carries at most four sequencers.
  generate
    if (NUM_SEQ < 1 || NUM_SEQ > asirq_pkg::MAX_SEQ) begin : g_bad_num_seq
      $error("NUM_SEQ must lie between 1 and 4.");
    end
  endgenerate

  localparam int SEL_W = asirq_pkg::TRIG_W * NUM_SEQ;

  // ==========================================================================
  // State
  logic [NUM_SEQ-1:0] promote_en;
  logic [NUM_SEQ-1:0] raw_irq;
  logic [NUM_SEQ-1:0] fifo_overrun;
  logic [SEL_W-1:0]   trig_src;
  logic               pin_s1;
  logic               pin_s2;
  logic               pin_s3;
  logic               pin_level;
  logic               pin_pulse;

  // ==========================================================================
  // Write decode
  wire wr_mask = wr_i && (addr_i == asirq_pkg::OFF_MASK);
  wire wr_isc  = wr_i && (addr_i == asirq_pkg::OFF_ISC);
  wire wr_ovf  = wr_i && (addr_i == asirq_pkg::OFF_OVF);
  wire wr_trig = wr_i && (addr_i == asirq_pkg::OFF_TRIG_SEL);

  wire [NUM_SEQ-1:0] isc_clear = wr_isc ? wdata_i[NUM_SEQ-1:0] : '0; // R3
  wire [NUM_SEQ-1:0] ovf_clear = wr_ovf ? wdata_i[NUM_SEQ-1:0] : '0; // R7

  // ==========================================================================
  // Raw and masked interrupt status
  wire [NUM_SEQ-1:0] raw_set = sample_done_i & sample_irq_enable_i; // R12
  // A set arriving with a clear wins, so no completion is ever lost.
  // The clear ignores the mask so polling software can drain raw flags.
  wire [NUM_SEQ-1:0] next_raw_irq = (raw_irq & ~isc_clear) | raw_set; // R3 R4
  wire [NUM_SEQ-1:0] next_promote_en = wr_mask ? wdata_i[NUM_SEQ-1:0] : promote_en;
  wire [NUM_SEQ-1:0] masked_irq = raw_irq & promote_en; // R2
  wire [NUM_SEQ-1:0] next_masked_irq = next_raw_irq & next_promote_en; // R1 R5
  wire               next_irq = |next_masked_irq; // R1

  // ==========================================================================
  // FIFO overflow
  wire [NUM_SEQ-1:0] ovf_set = fifo_wr_req_i & fifo_full_i; // R6
  wire [NUM_SEQ-1:0] next_fifo_wr_en = fifo_wr_req_i & ~fifo_full_i; // R6
  wire [NUM_SEQ-1:0] next_fifo_overrun = (fifo_overrun & ~ovf_clear) | ovf_set; // R7

  // ==========================================================================
  // Trigger select
  wire [SEL_W-1:0] next_trig_src = wr_trig ? wdata_i[SEL_W-1:0] : trig_src; // R8

  // ==========================================================================
  // External pin conditioning
  // The filtered level moves only when the second and third stages agree.
  wire pin_agree      = (pin_s2 == pin_s3);
  wire next_pin_level = pin_agree ? pin_s3 : pin_level;
  wire next_pin_pulse = next_pin_level && !pin_level;

  // ==========================================================================
  // Trigger multiplexer
  asirq_trig_if #(.NUM_SEQ(NUM_SEQ)) tif ();

  assign tif.sel   = trig_src;
  assign tif.cmp   = trig_cmp_i;
  assign tif.pin   = pin_pulse;
  assign tif.timer = trig_timer_i;
  assign tif.pwm   = trig_pwm_i;
  assign tif.sw    = sw_initiate_i;

  asirq_trig_mux #(
    .NUM_SEQ (NUM_SEQ)
  ) u_trig_mux (
    .tif (tif.mux)
  );

  // ==========================================================================
  // Read decode
  // Reserved bits read as zero, as does any unmapped address.
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = asirq_pkg::READ_IDLE;
    if (!rd_i) begin
      next_rdata = asirq_pkg::READ_IDLE;
    end else if (addr_i == asirq_pkg::OFF_RAW_IRQ) begin
      next_rdata = {{(32-NUM_SEQ){1'b0}}, raw_irq};
    end else if (addr_i == asirq_pkg::OFF_MASK) begin
      next_rdata = {{(32-NUM_SEQ){1'b0}}, promote_en};
    end else if (addr_i == asirq_pkg::OFF_ISC) begin
      next_rdata = {{(32-NUM_SEQ){1'b0}}, masked_irq}; // R2
    end else if (addr_i == asirq_pkg::OFF_OVF) begin
      next_rdata = {{(32-NUM_SEQ){1'b0}}, fifo_overrun};
    end else if (addr_i == asirq_pkg::OFF_TRIG_SEL) begin
      next_rdata = {{(32-SEL_W){1'b0}}, trig_src};
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      promote_en   <= asirq_pkg::RST_MASK[NUM_SEQ-1:0];
      raw_irq      <= asirq_pkg::RST_RAW_IRQ[NUM_SEQ-1:0];
      fifo_overrun <= asirq_pkg::RST_OVF[NUM_SEQ-1:0];
      trig_src     <= asirq_pkg::RST_TRIG_SEL[SEL_W-1:0];
    end else begin
      promote_en   <= next_promote_en;
      raw_irq      <= next_raw_irq;
      fifo_overrun <= next_fifo_overrun;
      trig_src     <= next_trig_src;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1    <= 1'b0;
      pin_s2    <= 1'b0;
      pin_s3    <= 1'b0;
      pin_level <= 1'b0;
      pin_pulse <= 1'b0;
    end else begin
      pin_s1    <= trig_pin_i;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_level <= next_pin_level;
      pin_pulse <= next_pin_pulse;
    end
  end

  // Outputs are registered, so each lags its cause by one clock, except a pin trigger, which lags trig_pin_i by five.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o       <= asirq_pkg::READ_IDLE;
      seq_irq_o     <= '0;
      irq_o         <= 1'b0;
      fifo_wr_en_o  <= '0;
      seq_trigger_o <= '0;
    end else begin
      rdata_o       <= next_rdata;
      seq_irq_o     <= next_masked_irq; // R5
      irq_o         <= next_irq; // R1
      fifo_wr_en_o  <= next_fifo_wr_en; // R6
      seq_trigger_o <= tif.fire; // R10
    end
  end

endmodule : asirq_regs

// [logic/asirq_trig_if.sv]
// Trigger sources and selections passed from the register block to the trigger mux.
`timescale 1ns/1ps
interface asirq_trig_if #(
  parameter int NUM_SEQ = 4
);
  logic [4*NUM_SEQ-1:0] sel;
  logic                 cmp;
  logic                 pin;
  logic                 timer;
  logic                 pwm;
  logic [NUM_SEQ-1:0]   sw;
  logic [NUM_SEQ-1:0]   fire;

  modport src (output sel, output cmp, output pin, output timer, output pwm, output sw, input fire);
  modport mux (input sel, input cmp, input pin, input timer, input pwm, input sw, output fire);
endinterface : asirq_trig_if

// [logic/asirq_trig_mux.sv]
// Per-sequencer trigger source multiplexer.
`timescale 1ns/1ps
module asirq_trig_mux #(
  parameter int NUM_SEQ = 4
) (
  asirq_trig_if.mux tif
);

  // ==========================================================================
  // One selector per sequencer
  genvar g;
  generate
    for (g = 0; g < NUM_SEQ; g++) begin : g_seq
      wire [3:0] code;
      wire       hit_sw;
      wire       hit_cmp;
      wire       hit_pin;
      wire       hit_timer;
      wire       hit_pwm;
      wire       hit_always;
      assign code       = tif.sel[4*g +: 4]; // R10
      assign hit_sw     = (code == asirq_pkg::TRIG_SW) && tif.sw[g]; // R9
      assign hit_cmp    = (code == asirq_pkg::TRIG_CMP) && tif.cmp; // R9
      assign hit_pin    = (code == asirq_pkg::TRIG_PIN) && tif.pin; // R9
      assign hit_timer  = (code == asirq_pkg::TRIG_TIMER) && tif.timer; // R9
      assign hit_pwm    = (code == asirq_pkg::TRIG_PWM) && tif.pwm; // R9
      assign hit_always = (code == asirq_pkg::TRIG_ALWAYS); // R9
      // Any other code matches none of the terms and so never fires.
      assign tif.fire[g] = hit_sw | hit_cmp | hit_pin | hit_timer | hit_pwm | hit_always; // R13
    end
  endgenerate

endmodule : asirq_trig_mux

// [test/asirq_fifo_model.sv]
// Behavioural result FIFOs of the four sequencers, facing the register block.
`timescale 1ns/1ps
module asirq_fifo_model #(
  parameter int DEPTH = 2
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [3:0] push_i,
  input  wire logic [3:0] pop_i,
  input  wire logic [3:0] wr_en_i,
  output logic      [3:0] req_o,
  output logic      [3:0] full_o
);
  // ==========================================================================
  // Fill counters
  int unsigned fill [4];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_o <= '0;
      fill  <= '{default: 0};
    end else begin
      req_o <= push_i;
      for (int i = 0; i < 4; i++) begin
        fill[i] <= fill[i] + int'(wr_en_i[i]) - int'(pop_i[i] && fill[i] > 0);
      end
    end
  end
  // Full follows only accepted writes, so a request issued too soon after the last one is still accepted.
  always_comb for (int i = 0; i < 4; i++) full_o[i] = fill[i] >= DEPTH;
endmodule : asirq_fifo_model

// [test/asirq_regs_monitor.sv]
// Port checker of the sequencer interrupt and trigger register block.
`timescale 1ns/1ps
module asirq_regs_monitor #(
  parameter int NUM_SEQ = 4
) (
  input wire logic               clk_i,
  input wire logic               sys_rst_i,
  input wire logic [11:0]        addr_i,
  input wire logic [31:0]        wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [31:0]        rdata_o,
  input wire logic [NUM_SEQ-1:0] sample_done_i,
  input wire logic [NUM_SEQ-1:0] sample_irq_enable_i,
  input wire logic [NUM_SEQ-1:0] fifo_wr_req_i,
  input wire logic [NUM_SEQ-1:0] fifo_full_i,
  input wire logic [NUM_SEQ-1:0] fifo_wr_en_o,
  input wire logic [NUM_SEQ-1:0] sw_initiate_i,
  input wire logic [NUM_SEQ-1:0] seq_trigger_o,
  input wire logic [NUM_SEQ-1:0] seq_irq_o,
  input wire logic               irq_o
);
  // ==========================================================================
  // Shadows, since mask and selects are not visible at the ports
  logic [NUM_SEQ-1:0] shadow_mask;
  logic [3:0]         shadow_sel0;
  wire wr_mask = wr_i && addr_i == asirq_pkg::OFF_MASK;
  wire wr_isc0 = wr_i && addr_i == asirq_pkg::OFF_ISC && wdata_i[0];
  wire ev0     = sample_done_i[0] && sample_irq_enable_i[0];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shadow_mask <= '0;
      shadow_sel0 <= '0;
    end else begin
      if (wr_mask) shadow_mask <= wdata_i[NUM_SEQ-1:0];
      if (wr_i && addr_i == asirq_pkg::OFF_TRIG_SEL) shadow_sel0 <= wdata_i[3:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_irq_or: assert property (irq_o == |seq_irq_o)
    else $error("irq output is not the OR of sequencer lines");
  a_mask_gate: assert property ((seq_irq_o & ~shadow_mask) == '0)
    else $error("masked sequencer interrupt reached output");
  a_irq_hold: assert property (seq_irq_o[0] && !wr_isc0 && !wr_mask |=> seq_irq_o[0])
    else $error("sequencer interrupt dropped without clear");
  a_raw_set: assert property (ev0 && shadow_mask[0] && !wr_mask |=> seq_irq_o[0])
    else $error("finished sample did not raise interrupt");
  a_isc_clear: assert property (wr_isc0 && !ev0 |=> !seq_irq_o[0])
    else $error("write of one did not clear interrupt");
  a_fifo_pass: assert property (fifo_wr_en_o == $past(fifo_wr_req_i & ~fifo_full_i))
    else $error("fifo write enable wrong");
  a_rd_idle: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data outside read cycle");
  a_trig_sw: assert property (sw_initiate_i[0] && shadow_sel0 == asirq_pkg::TRIG_SW |=> seq_trigger_o[0])
    else $error("software trigger lost");
  a_trig_always: assert property (shadow_sel0 == asirq_pkg::TRIG_ALWAYS |=> seq_trigger_o[0])
    else $error("continuous trigger gap");
  a_trig_rsv: assert property (shadow_sel0 inside {4'h2, 4'h3, 4'h7, [4'h8:4'he]} |=> !seq_trigger_o[0])
    else $error("reserved code fired");
  c_irq: cover property (irq_o);
  c_overflow: cover property (fifo_wr_req_i[0] && fifo_full_i[0]);
  c_always: cover property (shadow_sel0 == asirq_pkg::TRIG_ALWAYS);
endmodule : asirq_regs_monitor
bind asirq_regs asirq_regs_monitor #(.NUM_SEQ(NUM_SEQ)) u_mon (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .sample_done_i, .sample_irq_enable_i, .fifo_wr_req_i, .fifo_full_i, .fifo_wr_en_o,
  .sw_initiate_i, .seq_trigger_o, .seq_irq_o, .irq_o);

// [test/asirq_regs_tb.sv]
// Self-checking bench of the sequencer interrupt and trigger registers.
`timescale 1ns/1ps
module asirq_regs_tb;
  // ==========================================================================
  // Signals and instances
  logic        clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, cmp = 0, pin = 0, tmr = 0, pwm = 0, irq;
  logic [11:0] addr_i = '0;
  logic [31:0] wdata_i = '0, rdata_o;
  logic [3:0]  done = '0, ie = '0, push = '0, pop = '0, sw = '0, req, full, wen, trg, sirq;
  int          n_errors = 0, checked = 0;
  asirq_regs dut (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_done_i(done),
    .sample_irq_enable_i(ie), .fifo_wr_req_i(req), .fifo_full_i(full), .fifo_wr_en_o(wen), .sw_initiate_i(sw),
    .trig_cmp_i(cmp), .trig_pin_i(pin), .trig_timer_i(tmr), .trig_pwm_i(pwm), .seq_trigger_o(trg),
    .seq_irq_o(sirq), .irq_o(irq));
  asirq_fifo_model fifo (.clk_i, .sys_rst_i, .push_i(push), .pop_i(pop), .wr_en_i(wen), .req_o(req), .full_o(full));
  initial forever #2.5 clk_i = ~clk_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    @(negedge clk_i);
    chk(rdata_o, e);
  endtask : rd
  task t_reset;
    logic [11:0] offs [6] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
    foreach (offs[i]) rd(offs[i], 32'h0);
  endtask : t_reset
  task t_irq;
    wr(asirq_pkg::OFF_MASK, 32'h5);
    rd(asirq_pkg::OFF_MASK, 32'h5);
    @(posedge clk_i);
    done <= 4'hf;
    ie <= 4'hb;
    @(posedge clk_i);
    done <= '0;
    ie <= '0;
    rd(asirq_pkg::OFF_RAW_IRQ, 32'hb);
    rd(asirq_pkg::OFF_ISC, 32'h1);
    chk(irq, 1'b1);
    wr(asirq_pkg::OFF_MASK, 32'h0);
    @(negedge clk_i);
    chk(sirq, 4'h0);
    chk(irq, 1'b0);
    wr(asirq_pkg::OFF_MASK, 32'h5);
    @(negedge clk_i);
    chk(sirq, 4'h1);
    wr(asirq_pkg::OFF_ISC, 32'h0);
    rd(asirq_pkg::OFF_RAW_IRQ, 32'hb);
    wr(asirq_pkg::OFF_ISC, 32'h2);
    rd(asirq_pkg::OFF_RAW_IRQ, 32'h9);
    wr(asirq_pkg::OFF_ISC, 32'h9);
    rd(asirq_pkg::OFF_RAW_IRQ, 32'h0);
    chk(irq, 1'b0);
  endtask : t_irq
  task t_fifo;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      push <= 4'h1;
      @(posedge clk_i);
      push <= 4'h0;
      @(posedge clk_i);
      @(negedge clk_i);
      chk(wen, {3'b000, k < 2});
      repeat (2) @(posedge clk_i);
    end
    rd(asirq_pkg::OFF_OVF, 32'h1);
    wr(asirq_pkg::OFF_OVF, 32'h0);
    rd(asirq_pkg::OFF_OVF, 32'h1);
    wr(asirq_pkg::OFF_OVF, 32'h1);
    rd(asirq_pkg::OFF_OVF, 32'h0);
  endtask : t_fifo
  task t_trig;
    logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'hf, 4'h2, 4'h3, 4'h7, 4'h8, 4'he};
    foreach (codes[i]) begin
      wr(asirq_pkg::OFF_TRIG_SEL, {16'h0, 4'h6, 4'h2, 4'h0, codes[i]});
      @(posedge clk_i);
      {sw, cmp, tmr, pwm} <= {4'h1, 3'b111};
      @(posedge clk_i);
      {sw, cmp, tmr, pwm} <= '0;
      @(negedge clk_i);
      chk(trg, {3'b100, codes[i] inside {4'h0, 4'h1, 4'h5, 4'h6, 4'hf}});
      @(negedge clk_i);
      chk(trg, {3'b000, codes[i] == 4'hf});
    end
  endtask : t_trig
  task t_pin;
    logic hit;
    hit = 0;
    wr(asirq_pkg::OFF_TRIG_SEL, 32'h4000);
    pin <= 1;
    for (int k = 0; k < 10 && !hit; k++) begin
      @(negedge clk_i);
      hit = trg[3];
    end
    chk(hit, 1'b1);
    @(negedge clk_i);
    chk(trg, 4'h0);
    pin <= 0;
  endtask : t_pin
  task end_of_test;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 0;
    t_reset();
    t_irq();
    t_fifo();
    t_trig();
    t_pin();
    end_of_test();
  end
endmodule : asirq_regs_tb
